// File: hdl/rrn_cfg.svh
// Constants for the rotate-right-without-carry executor.
// Assumes it is included by bare name from the design and bench files.
`ifndef RRN_CFG_SVH
`define RRN_CFG_SVH
`define RRN_OPC_MATCH      6'h10
`define RRN_OPC_HI         15
`define RRN_OPC_LO         10
`define RRN_DBIT           9
`define RRN_ABIT           8
`define RRN_IDX_LIMIT      8'h5f
`define RRN_ACCESS_SPLIT   8'h80
`define RRN_BANK_W         4
`define RRN_ADDR_W         12
`define RRN_STAT_N         4
`define RRN_STAT_Z         2
`define RRN_OFF_CTRL       12'h000
`define RRN_OFF_INSTR      12'h004
`define RRN_OFF_BANK       12'h008
`define RRN_OFF_WREG       12'h00c
`define RRN_OFF_STATUS     12'h010
`define RRN_OFF_FSR2       12'h014
`define RRN_OFF_RESULT     12'h018
`define RRN_OFF_MEMWIN     12'h800
`define RRN_CTRL_EXT       0
`define RRN_CTRL_GO        1
`endif

// File: hdl/rrn_exec.sv
// Rotate-right-without-carry executor with its data memory, reached over APB.
// Assumes one clock and a well-behaved APB master.
// Functional notes
// - Recognise opcode 010000, then d bit, a bit, 8-bit file address.
// - Result bit n-1 takes source bit n; source bit 0 enters bit 7.
// - d=0 writes the working register; d=1 writes the file register back.
// - a=0 uses the access bank; a=1 lets the bank pointer choose the bank.
// - Extended set with a=0 and f up to 95 uses indexed literal offset.
// - Only the negative and zero flags change.
// - File address spans 0..255; d and a are single bits.
// - One program word, one instruction cycle.
// - Decode Q1, read Q2, compute Q3, write destination Q4.
`timescale 1ns/1ps
`include "rrn_cfg.svh"
module rrn_exec
  import rrn_pkg::*;
#(
  parameter int AW = `RRN_ADDR_W
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Execution status.
  output logic             busy,
  output logic             illegal_op
);
  if (AW != `RRN_ADDR_W) begin : g_bad_aw
    $error("rrn_exec: AW must equal the 12-bit data space");
  end

  rrn_phase_e    phase_q;
  logic [15:0]   instr_q;
  logic [3:0]    bank_pointer_value_q;
  logic [7:0]    wreg_q;
  logic [7:0]    status_q;
  logic [7:0]    fsr2_q;
  logic          ext_q;
  logic [7:0]    result_q;
  logic          dsel_q;
  logic [AW-1:0] eff_addr_q;
  logic [AW-1:0] eff_addr_d;
  logic          rotate_right_no_carry_op;
  logic          apb_wr;
  logic          apb_rd;
  logic          mem_hit;
  logic          go_wr;
  logic [7:0]    rd_byte;
  logic [7:0]    rot;
  logic          ram_we;
  logic [AW-1:0] ram_waddr;
  logic [7:0]    ram_wdata;
  logic [AW-1:0] ram_raddr;
  logic          rd_pend_q;

  assign rotate_right_no_carry_op =
    (instr_q[`RRN_OPC_HI:`RRN_OPC_LO] == `RRN_OPC_MATCH);
  assign rot     = {rd_byte[0], rd_byte[7:1]};
  assign apb_wr  = psel && penable && pwrite && pready;
  assign apb_rd  = psel && !penable && !pwrite;
  assign mem_hit = paddr[11];
  assign go_wr   = apb_wr && (paddr == `RRN_OFF_CTRL) && pwdata[`RRN_CTRL_GO];

  // Address the operand: indexed, access bank or banked, all from the 8-bit f.
  always_comb begin
    eff_addr_d = {bank_pointer_value_q, instr_q[7:0]};
    if (!instr_q[`RRN_ABIT]) begin
      if (ext_q && (instr_q[7:0] <= `RRN_IDX_LIMIT)) begin
        eff_addr_d = AW'({4'h0, fsr2_q} + {4'h0, instr_q[7:0]});
      end else if (instr_q[7:0] < `RRN_ACCESS_SPLIT) begin
        eff_addr_d = {4'h0, instr_q[7:0]};
      end else begin
        eff_addr_d = {4'hf, instr_q[7:0]};
      end
    end
  end

  // Memory ports are shared: the executor takes the read port in Q2 and the write port in Q4.
  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = eff_addr_q;
    ram_wdata = result_q;
    ram_raddr = paddr[AW-1:0] - AW'(`RRN_OFF_MEMWIN);
    if (phase_q == RRN_Q2) begin
      ram_raddr = eff_addr_q;
    end
    if (phase_q == RRN_Q4) begin
      ram_we = dsel_q;
    end else if (apb_wr && mem_hit) begin
      ram_we    = 1'b1;
      ram_waddr = paddr[AW-1:0] - AW'(`RRN_OFF_MEMWIN);
      ram_wdata = pwdata[7:0];
    end
  end

  rrn_ram #(.AW(AW), .DW(8)) u_ram (
    .clk   (pclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (rd_byte)
  );

  // One instruction cycle of four phases, started by the go bit; a foreign opcode returns to idle after Q1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= RRN_IDLE;
    end else begin
      unique case (phase_q)
        RRN_IDLE: if (go_wr) phase_q <= RRN_Q1;
        RRN_Q1:   phase_q <= rotate_right_no_carry_op ? RRN_Q2 : RRN_IDLE;
        RRN_Q2:   phase_q <= RRN_Q3;
        RRN_Q3:   phase_q <= RRN_Q4;
        RRN_Q4:   phase_q <= RRN_IDLE;
      endcase
    end
  end

  // Decode in Q1: latch destination and effective address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsel_q     <= 1'b0;
      eff_addr_q <= '0;
      illegal_op <= 1'b0;
    end else if (phase_q == RRN_Q1) begin
      dsel_q     <= instr_q[`RRN_DBIT];
      eff_addr_q <= eff_addr_d;
      illegal_op <= !rotate_right_no_carry_op;
    end
  end

  // Compute in Q3, flags update alongside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 8'h00;
    end else if (phase_q == RRN_Q3) begin
      result_q <= rot;
    end
  end

  // Software registers; during execution flags and W belong to the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q              <= 16'h0000;
      bank_pointer_value_q <= 4'h0;
      wreg_q               <= 8'h00;
      status_q             <= 8'h00;
      fsr2_q               <= 8'h00;
      ext_q                <= 1'b0;
    end else begin
      if (apb_wr && !busy) begin
        unique case (paddr)
          `RRN_OFF_CTRL:   ext_q                <= pwdata[`RRN_CTRL_EXT];
          `RRN_OFF_INSTR:  instr_q              <= pwdata[15:0];
          `RRN_OFF_BANK:   bank_pointer_value_q <= pwdata[3:0];
          `RRN_OFF_WREG:   wreg_q               <= pwdata[7:0];
          `RRN_OFF_STATUS: status_q             <= pwdata[7:0];
          `RRN_OFF_FSR2:   fsr2_q               <= pwdata[7:0];
          default: ;
        endcase
      end
      if (phase_q == RRN_Q3) begin
        status_q[`RRN_STAT_N] <= rot[7];
        status_q[`RRN_STAT_Z] <= (rot == 8'h00);
      end
      if ((phase_q == RRN_Q4) && !dsel_q) begin
        wreg_q <= result_q;
      end
    end
  end

  // APB answer: registers with no wait state, memory window reads in one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
      busy      <= 1'b0;
    end else begin
      // Busy follows the next phase, so it falls with the write-back edge.
      busy      <= ((phase_q == RRN_IDLE) && go_wr)
                   || ((phase_q == RRN_Q1) && rotate_right_no_carry_op)
                   || (phase_q == RRN_Q2) || (phase_q == RRN_Q3);
      rd_pend_q <= apb_rd && mem_hit && (phase_q == RRN_IDLE) && !go_wr;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      if (psel && !penable && !(mem_hit && !pwrite)) begin
        pready  <= 1'b1;
        pslverr <= !mem_hit && (paddr > `RRN_OFF_RESULT);
        unique case (paddr)
          `RRN_OFF_CTRL:   prdata <= {30'h0, busy, ext_q};
          `RRN_OFF_INSTR:  prdata <= {16'h0, instr_q};
          `RRN_OFF_BANK:   prdata <= {28'h0, bank_pointer_value_q};
          `RRN_OFF_WREG:   prdata <= {24'h0, wreg_q};
          `RRN_OFF_STATUS: prdata <= {24'h0, status_q};
          `RRN_OFF_FSR2:   prdata <= {24'h0, fsr2_q};
          `RRN_OFF_RESULT: prdata <= {23'h0, illegal_op, result_q};
          default:         prdata <= 32'h0000_0000;
        endcase
      end else if (rd_pend_q) begin
        pready <= 1'b1;
        prdata <= {24'h0, rd_byte};
      end
    end
  end

  a_rot_value: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q3) |=> ({result_q[6:0], result_q[7]} == $past(rd_byte)))
    else $error("rotated result wrong");
  a_busy_phase: assert property (@(posedge pclk) disable iff (!presetn)
    busy == (phase_q != RRN_IDLE))
    else $error("busy does not track the instruction cycle");
  a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q2) |=> (phase_q == RRN_Q3) ##1 (phase_q == RRN_Q4) ##1 (phase_q == RRN_IDLE))
    else $error("instruction cycle not four phases");
  a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q1) && rotate_right_no_carry_op |=> (phase_q == RRN_Q2))
    else $error("read phase does not follow decode");
  a_decode_only: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q1) && !rotate_right_no_carry_op |=> (phase_q == RRN_IDLE) && illegal_op)
    else $error("foreign opcode executed");
  a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q4) |-> (status_q[`RRN_STAT_Z] == (result_q == 8'h00))
    && (status_q[`RRN_STAT_N] == result_q[7]))
    else $error("negative or zero flag wrong");
  a_other_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q3) |=> ((status_q & 8'heb) == ($past(status_q) & 8'heb)))
    else $error("other status bits changed");
  a_w_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q4) && !dsel_q |-> !ram_we ##1 (wreg_q == $past(result_q)))
    else $error("working register destination wrong");
  a_f_dest: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q4) && dsel_q |-> ram_we && (ram_waddr == eff_addr_q)
    && (ram_wdata == result_q))
    else $error("file register destination wrong");
  a_access_bank: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q1) && !instr_q[`RRN_ABIT] && !ext_q |=>
    (eff_addr_q[11:8] == (instr_q[7] ? 4'hf : 4'h0)))
    else $error("access bank not selected");
  a_indexed: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == RRN_Q1) && !instr_q[`RRN_ABIT] && ext_q && (instr_q[7:0] <= 8'h5f) |=>
    (eff_addr_q == ({4'h0, $past(fsr2_q)} + {4'h0, instr_q[7:0]})))
    else $error("indexed literal offset not applied");
endmodule : rrn_exec

// File: hdl/rrn_pkg.sv
// Types for the rotate-right-without-carry executor.
// Assumes the constants header is compiled alongside.
package rrn_pkg;
  typedef enum logic [4:0] {
    RRN_IDLE = 5'b00001,
    RRN_Q1   = 5'b00010,
    RRN_Q2   = 5'b00100,
    RRN_Q3   = 5'b01000,
    RRN_Q4   = 5'b10000
  } rrn_phase_e;
endpackage : rrn_pkg

// File: hdl/rrn_ram.sv
// Data memory of the core: one write port, one registered read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ps
module rrn_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock.
  input  wire logic          clk,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  if ((AW < 1) || (DW < 1)) begin : g_bad_param
    $error("rrn_ram: AW and DW must be at least one bit");
  end

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : rrn_ram

// File: verif/rrn_mem_mdl.sv
// Bench image of the core data memory and of the rotate datapath.
// Assumes the bench updates it on every memory write it issues.
`timescale 1ns/1ps
module rrn_mem_mdl;
  logic [7:0] mem [0:2047];

  function automatic logic [7:0] rot(input logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction : rot

  // Mask 8'heb keeps every status bit except N and Z.
  function automatic logic [7:0] flags(input logic [7:0] s, input logic [7:0] r);
    return (s & 8'heb) | {3'h0, r[7], 1'b0, r == 8'h00, 2'h0};
  endfunction : flags
endmodule : rrn_mem_mdl

// File: verif/tb.sv
// Self-checking bench: random rotate instructions issued over APB.
// Assumes only the lower 2K of data memory is reachable through the window.
`timescale 1ns/1ps
`include "rrn_cfg.svh"
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        illegal_op;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          bc = 0;
  int          b0;
  logic [31:0] seed = 32'h15b;
  logic [31:0] r, q;
  logic        e, ext, d, a;
  logic [7:0]  f, fsr, v, s, w, rr;
  logic [3:0]  bk;
  logic [11:0] ad;

  rrn_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .illegal_op(illegal_op));
  rrn_mem_mdl pm ();

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) if (busy === 1'b1) bc <= bc + 1;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request is held from setup until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] ad_i, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad_i;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      wrap_up();
    end
    @(posedge pclk);
  endtask : apb

  // Polls the busy bit; the instruction must finish within one cycle of four phases.
  task automatic go();
    int i;
    b0 = bc;
    apb(1'b1, `RRN_OFF_CTRL, {30'h0, 1'b1, ext});
    for (i = 0; i < 50; i++) begin
      apb(1'b0, `RRN_OFF_CTRL, 32'h0);
      if (q[1] === 1'b0) break;
    end
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end
    chk(32'((bc - b0) > 0 && (bc - b0) <= 4), 32'h1);
  endtask : go

  function automatic logic [11:0] eff();
    if (!a && ext && f <= 8'h5f) return {4'h0, fsr} + {4'h0, f};
    if (!a) return f[7] ? {4'hf, f} : {4'h0, f};
    return {bk, f};
  endfunction : eff

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 40; k++) begin
      r = xs();
      {ext, d, a} = r[2:0];
      f = r[15:8];
      fsr = r[23:16];
      bk = {1'b0, r[26:24]};
      v = r[28] ? 8'h00 : 8'(xs());
      s = r[31:24];
      w = r[7:0];
      // The upper access bank half sits outside the APB memory window.
      if (!a && f[7]) a = 1'b1;
      if (k == 0) v = 8'hd7;
      ad = eff();
      apb(1'b1, 12'h800 | ad, {24'h0, v});
      pm.mem[ad[10:0]] = v;
      apb(1'b1, `RRN_OFF_STATUS, {24'h0, s});
      apb(1'b1, `RRN_OFF_WREG, {24'h0, w});
      apb(1'b1, `RRN_OFF_INSTR, {16'h0, 6'h10, d, a, f});
      apb(1'b1, `RRN_OFF_BANK, {28'h0, bk});
      apb(1'b1, `RRN_OFF_FSR2, {24'h0, fsr});
      go();
      rr = pm.rot(pm.mem[ad[10:0]]);
      if (d) pm.mem[ad[10:0]] = rr;
      apb(1'b0, `RRN_OFF_RESULT, 32'h0);
      chk(q, {24'h0, rr});
      apb(1'b0, `RRN_OFF_WREG, 32'h0);
      chk(q, {24'h0, d ? w : rr});
      apb(1'b0, 12'h800 | ad, 32'h0);
      chk(q, {24'h0, pm.mem[ad[10:0]]});
      apb(1'b0, `RRN_OFF_STATUS, 32'h0);
      chk(q, {24'h0, pm.flags(s, rr)});
    end
    $display("test random rotate done");
    apb(1'b1, `RRN_OFF_INSTR, 32'h0000fc00);
    go();
    apb(1'b0, `RRN_OFF_RESULT, 32'h0);
    chk({31'h0, q[8]}, 32'h1);
    chk({31'h0, illegal_op}, 32'h1);
    chk({31'h0, e}, 32'h0);
    $display("test illegal opcode done");
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test unmapped read done");
    wrap_up();
  end
endmodule : tb
